// *** rtl/host_bus_port.sv ***
// Indexed host bus port: 8/16-bit host in, 32-bit internal accesses out.
// Assumes host pins are asynchronous, polarity already resolved, and
// that internal read data answers int_rd_addr within one clock.
//
// How it works
// - bits 0-3 pick byte order, reset little
// - four shadow copies, any set sets all
// - index and config stored piece by piece
// - write cycle is cs with wr or strobe
// - config and index take data at trailing edge
// - lanes from order bit and low address
// - writes dropped after reset until a read
// - writes dropped in low power until a read
// - read cycle selects register and drives data
// - two or four pieces make one doubleword
// - each path has its own conversion state
// - leading edge latches address and index
// - trailing edge loads assembly lane, order swapped
// - own counter and assembly per path
// - last piece issues one internal write
// - low power clears write counters
// - read latches index and address, steps counter
// - read lane from order bit and address
// - separate read counters per path
// - single internal read at last piece end
// - low power clears read counters
// - 8-bit byte address, 16-bit word address
// - fifo address bypasses index registers
`timescale 1ns/1ps
`include "host_port_regs.svh"

module host_bus_port (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Host pins, asynchronous
  input  wire host_port_pkg::host_pins_t host_ctl,
  input  wire logic [4:0]               host_addr,
  input  wire logic [15:0]              host_din,
  output logic [15:0]                   host_dout,
  output logic                          host_doe,
  // Mode straps, asynchronous
  input  wire logic                     mode16_pin,
  input  wire logic                     alt_signal_pin,
  // Power state, same clock, high when not full_power_state
  input  wire logic                     low_power,
  // Internal write
  output logic                          int_wr_strobe,
  output host_port_pkg::int_req_t       int_wr_req,
  // Internal read
  output logic [15:0]                   int_rd_addr,
  output logic                          int_rd_fifo,
  output logic                          int_rd_strobe,
  input  wire logic [31:0]              int_rd_data
);

  import host_port_pkg::*;

  // ==========================================================
  // Input synchronisers
  localparam int SW = 5 + 5 + 16 + 2;    // Synchronised bit count
  logic [SW-1:0] s1_ff;                  // First stage, read by s2 only
  logic [SW-1:0] s2_ff;                  // Second stage, used by logic
  logic [SW-1:0] nxt_s1;
  logic [SW-1:0] nxt_s2;
  host_pins_t    ctl;                    // Synchronised control
  logic [4:0]    addr_raw;               // Synchronised address
  logic [15:0]   din;                    // Synchronised data
  logic          m16;                    // 16-bit data mode
  logic          alt;                    // Transfer strobe signaling

  // Pack pins, then two stages
  always_comb begin
    nxt_s1 = {host_ctl, host_addr, host_din, mode16_pin, alt_signal_pin};
    nxt_s2 = s1_ff;
    {ctl, addr_raw, din, m16, alt} = s2_ff;
  end

  // Register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  // ==========================================================
  // Cycle decode and lane helpers
  logic       rd_act;                    // Read cycle present
  logic       wr_act;                    // Write cycle present
  logic [4:0] addr_now;                  // Host byte address

  always_comb begin
    rd_act   = ctl.cs && (alt ? (ctl.transfer_strobe && ctl.rnw) : ctl.rd);
    wr_act   = ctl.cs && (alt ? (ctl.transfer_strobe && !ctl.rnw) : ctl.wr);
    addr_now = m16 ? {addr_raw[4:1], 1'b0} : addr_raw;
  end

  // Lanes touched by one piece
  function automatic logic [3:0] lane_mask(input logic [1:0] a,
                                           input logic       mode16,
                                           input logic       big);
    logic [1:0] l;
    l = a ^ {big, big};
    if (mode16) begin
      lane_mask = l[1] ? 4'hC : 4'h3;
    end else begin
      lane_mask = 4'h1 << l;
    end
  endfunction

  // Piece taken from a little endian doubleword
  function automatic logic [15:0] lane_pick(input logic [31:0] w,
                                            input logic [1:0]  a,
                                            input logic        mode16,
                                            input logic        big);
    logic [1:0] l;
    l = a ^ {big, big};
    if (mode16) begin
      lane_pick = l[1] ? w[31:16] : w[15:0];
    end else begin
      lane_pick = {8'h00, w[8*l +: 8]};
    end
  endfunction

  // ==========================================================
  // Host cycle tracking, registers and outputs
  cyc_state_t    state_ff;               // Host cycle state
  logic [4:0]    cyc_addr_ff;            // Host address at leading edge
  logic [15:0]   cyc_idx_ff;             // Index value at leading edge
  logic [15:0]   wdata_ff;               // Last data seen in write
  logic          lock_ff;                // Writes being discarded
  logic [31:0]   cfg_ff;                 // host_byte_order_config
  logic [15:0]   idx_ff [3];             // Three index registers
  logic [15:0]   dout_ff;                // Host data out
  logic          doe_ff;                 // Host data enable
  logic          iwr_ff;                 // Internal write strobe
  int_req_t      ireq_ff;                // Internal write request
  logic [15:0]   irad_ff;                // Internal read address
  logic          irfifo_ff;              // Internal read from FIFO
  logic          irs_ff;                 // Internal read strobe

  cyc_state_t    nxt_state;
  logic [4:0]    nxt_cyc_addr;
  logic [15:0]   nxt_cyc_idx;
  logic [15:0]   nxt_wdata;
  logic          nxt_lock;
  logic [31:0]   nxt_cfg;
  logic [15:0]   nxt_idx [3];
  logic [15:0]   nxt_dout;
  logic          nxt_doe;
  logic          nxt_iwr;
  int_req_t      nxt_ireq;
  logic [15:0]   nxt_irad;
  logic          nxt_irfifo;
  logic          nxt_irs;

  // Conversion path wiring, index 3 is the FIFO path
  logic [3:0]    wr_piece;
  logic [3:0]    rd_piece;
  logic [3:0]    wr_last;
  logic [3:0]    rd_last;
  logic [31:0]   wr_full [4];
  logic [3:0]    be;                     // Lanes of the current piece
  logic [31:0]   word;                   // Piece replicated on lanes
  logic [2:0]    region;                 // Latched region
  logic [1:0]    path;                   // Latched path number
  logic          is_data;                // Latched region is a data path
  logic          big;                    // Byte order of the region
  logic [31:0]   src;                    // Doubleword under read
  logic [3:0]    grp;                    // New byte order bits
  logic [15:0]   lead_idx;               // Index named by live address, 0 past pairs

  for (genvar p = 0; p < 4; p++) begin : g_path
    path_conv u_conv (
      .clk      (clk),
      .rstn     (rstn),
      .clr      (low_power),
      .mode16   (m16),
      .wr_piece (wr_piece[p]),
      .wr_be    (be),
      .wr_word  (word),
      .wr_last  (wr_last[p]),
      .wr_full  (wr_full[p]),
      .rd_piece (rd_piece[p]),
      .rd_last  (rd_last[p])
    );
  end

  // Next values of the whole port
  always_comb begin
    nxt_state    = state_ff;
    nxt_cyc_addr = cyc_addr_ff;
    nxt_cyc_idx  = cyc_idx_ff;
    nxt_wdata    = wdata_ff;
    nxt_lock     = lock_ff;
    nxt_cfg      = cfg_ff;
    nxt_idx      = idx_ff;
    nxt_dout     = dout_ff;
    nxt_doe      = 1'b0;
    nxt_iwr      = 1'b0;
    nxt_ireq     = ireq_ff;
    nxt_irad     = irad_ff;
    nxt_irfifo   = irfifo_ff;
    nxt_irs      = 1'b0;
    wr_piece     = 4'h0;
    rd_piece     = 4'h0;
    grp          = 4'h0;
    // Region and path of the latched cycle
    region  = cyc_addr_ff[4:2];
    path    = (region == `REG_FIFO_DIRECT) ? `PATH_FIFO : region[2:1];
    is_data = (region[0] || (path == `PATH_FIFO)) && (region != `REG_HOST_BYTE_ORDER_CFG);
    lead_idx = (addr_now[4:3] == 2'h3) ? 16'h0000 : idx_ff[addr_now[4:3]];
    // order bit per pair and fifo
    big = (region == `REG_HOST_BYTE_ORDER_CFG) ? 1'b0 : cfg_ff[path];
    be   = lane_mask(cyc_addr_ff[1:0], m16, big);
    word = m16 ? {2{wdata_ff}} : {4{wdata_ff[7:0]}};
    // Source of read data
    if (is_data) begin
      src = int_rd_data;
    end else if (region == `REG_HOST_BYTE_ORDER_CFG) begin
      src = cfg_ff;
    end else begin
      src = {16'h0000, idx_ff[path]};
    end
    case (state_ff)
      CYC_IDLE: begin
        if (rd_act || wr_act) begin
          nxt_cyc_addr = addr_now;
          nxt_cyc_idx  = lead_idx;
          nxt_wdata    = din;
          nxt_state    = rd_act ? CYC_READ : CYC_WRITE;
        end
        if (rd_act) begin
          nxt_irad   = lead_idx;
          nxt_irfifo = (addr_now[4:2] == `REG_FIFO_DIRECT);
          // only a full power read counts
          if (!low_power) begin
            nxt_lock = 1'b0;
          end
        end
      end
      CYC_READ: begin
        nxt_dout = lane_pick(src, cyc_addr_ff[1:0], m16, big);
        nxt_doe  = rd_act && !low_power;
        if (!rd_act) begin
          nxt_state = CYC_IDLE;
          if (is_data && !low_power) begin
            rd_piece[path] = 1'b1;
            nxt_irs = rd_last[path];
          end
        end
      end
      CYC_WRITE: begin
        if (wr_act) begin
          nxt_wdata = din;
        end else begin
          nxt_state = CYC_IDLE;
          if (!lock_ff && !low_power) begin
            if (is_data) begin
              wr_piece[path] = 1'b1;
              if (wr_last[path]) begin
                nxt_iwr       = 1'b1;
                nxt_ireq.fifo = (path == `PATH_FIFO);
                nxt_ireq.addr = nxt_ireq.fifo ? 16'h0000 : cyc_idx_ff;
                nxt_ireq.data = wr_full[path];
              end
            end else if (region == `REG_HOST_BYTE_ORDER_CFG) begin
              for (int n = 0; n < 4; n++) begin
                for (int l = 0; l < 4; l++) begin
                  grp[n] = grp[n] | (be[l] & word[`CFG_GROUP_STRIDE*l + n]);
                end
              end
              nxt_cfg = {4{4'h0, grp}} & `CFG_LIVE_MASK;
            end else begin
              for (int l = 0; l < 2; l++) begin
                if (be[l]) begin
                  nxt_idx[path][8*l +: 8] = word[8*l +: 8];
                end
              end
            end
          end
        end
      end
      default: begin
        nxt_state = CYC_IDLE;
      end
    endcase
    if (low_power) begin
      nxt_lock = 1'b1;
    end
  end

  // Register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= CYC_IDLE;
      cyc_addr_ff <= 5'h00;
      cyc_idx_ff  <= 16'h0000;
      wdata_ff    <= 16'h0000;
      lock_ff     <= 1'b1;
      cfg_ff      <= `CFG_RESET;
      idx_ff      <= '{`INDEX_RESET, `INDEX_RESET, `INDEX_RESET};
      dout_ff     <= 16'h0000;
      doe_ff      <= 1'b0;
      iwr_ff      <= 1'b0;
      ireq_ff     <= '0;
      irad_ff     <= 16'h0000;
      irfifo_ff   <= 1'b0;
      irs_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cyc_addr_ff <= nxt_cyc_addr;
      cyc_idx_ff  <= nxt_cyc_idx;
      wdata_ff    <= nxt_wdata;
      lock_ff     <= nxt_lock;
      cfg_ff      <= nxt_cfg;
      idx_ff      <= nxt_idx;
      dout_ff     <= nxt_dout;
      doe_ff      <= nxt_doe;
      iwr_ff      <= nxt_iwr;
      ireq_ff     <= nxt_ireq;
      irad_ff     <= nxt_irad;
      irfifo_ff   <= nxt_irfifo;
      irs_ff      <= nxt_irs;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign host_dout     = dout_ff;
  assign host_doe      = doe_ff;
  assign int_wr_strobe = iwr_ff;
  assign int_wr_req    = ireq_ff;
  assign int_rd_addr   = irad_ff;
  assign int_rd_fifo   = irfifo_ff;
  assign int_rd_strobe = irs_ff;

endmodule // host_bus_port

// *** include/host_port_regs.svh ***
// Offsets, field positions, reset values and counts of the host bus port.
// Assumes inclusion by bare name from any file that needs these figures.
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ==========================================================
// Host address regions, host address bits [4:2]
`define REG_INDEX_PAIR0_ADDRESS  3'h0
`define REG_INDEX_PAIR0_WINDOW   3'h1
`define REG_INDEX_PAIR1_ADDRESS  3'h2
`define REG_INDEX_PAIR1_WINDOW   3'h3
`define REG_INDEX_PAIR2_ADDRESS  3'h4
`define REG_INDEX_PAIR2_WINDOW   3'h5
`define REG_FIFO_DIRECT          3'h6
`define REG_HOST_BYTE_ORDER_CFG  3'h7

// ==========================================================
// Byte order configuration fields
`define CFG_FIFO_ORDER_BIT       3
`define CFG_GROUP_STRIDE         8
`define CFG_RESET                32'h0000_0000
`define CFG_LIVE_MASK            32'h0F0F_0F0F

// ==========================================================
// Index registers
`define INDEX_RESET              16'h1234
`define INDEX_WIDTH              16

// ==========================================================
// Conversion counts
`define PATH_FIFO                2'h3
`define PIECES_8BIT              3'h4
`define PIECES_16BIT             3'h2

`endif

// *** include/host_port_pkg.sv ***
// Types shared by the host bus port and its conversion paths.
// Assumes nothing of its surroundings.
package host_port_pkg;

  // ========================================================
  // Host control pins, active high after polarity selection
  typedef struct packed {
    logic cs;      // Chip select
    logic rd;      // Read strobe
    logic wr;      // Write strobe
    logic transfer_strobe; // Strobe of the alternate signaling
    logic rnw;     // High = read in alternate signaling
  } host_pins_t;

  // ========================================================
  // One 32-bit internal write
  typedef struct packed {
    logic        fifo;   // Goes to the write FIFO, not a register
    logic [15:0] addr;   // Internal byte address
    logic [31:0] data;   // Little endian doubleword
  } int_req_t;

  // ========================================================
  // Host cycle tracker
  typedef enum logic [2:0] {
    CYC_IDLE  = 3'b001,
    CYC_READ  = 3'b010,
    CYC_WRITE = 3'b100
  } cyc_state_t;

endpackage

// *** rtl/path_conv.sv ***
// Piece to doubleword conversion for one data path.
// Assumes the caller gives one-cycle piece strobes and lane enables.
`timescale 1ns/1ps
`include "host_port_regs.svh"

module path_conv (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Control
  input  wire logic        clr,       // Power drop, counters to zero
  input  wire logic        mode16,    // 16-bit host data mode
  // Write side
  input  wire logic        wr_piece,  // Trailing edge of a write
  input  wire logic [3:0]  wr_be,     // Lanes carried by the piece
  input  wire logic [31:0] wr_word,   // Piece replicated on all lanes
  output logic             wr_last,   // This piece completes the doubleword
  output logic [31:0]      wr_full,   // Assembly with this piece merged
  // Read side
  input  wire logic        rd_piece,  // Trailing edge of a read
  output logic             rd_last    // This piece ends the doubleword
);

  import host_port_pkg::*;

  logic [2:0]  wr_cnt_ff;             // Write pieces seen
  logic [2:0]  rd_cnt_ff;             // Read pieces seen
  logic [31:0] asm_ff;                // Assembly register
  logic [2:0]  nxt_wr_cnt;
  logic [2:0]  nxt_rd_cnt;
  logic [31:0] nxt_asm;
  logic [2:0]  need;                  // Pieces per doubleword

  // ==========================================================
  // Counting and assembly
  always_comb begin
    need       = mode16 ? `PIECES_16BIT : `PIECES_8BIT;
    nxt_wr_cnt = wr_cnt_ff;
    nxt_rd_cnt = rd_cnt_ff;
    // Merge piece into its lanes only
    for (int l = 0; l < 4; l++) begin
      wr_full[8*l +: 8] = wr_be[l] ? wr_word[8*l +: 8] : asm_ff[8*l +: 8];
    end
    nxt_asm = wr_piece ? wr_full : asm_ff;
    wr_last = wr_piece && ((wr_cnt_ff + 3'h1) == need);
    rd_last = rd_piece && ((rd_cnt_ff + 3'h1) == need);
    if (wr_piece) begin
      nxt_wr_cnt = wr_last ? 3'h0 : wr_cnt_ff + 3'h1;
    end
    if (rd_piece) begin
      nxt_rd_cnt = rd_last ? 3'h0 : rd_cnt_ff + 3'h1;
    end
    if (clr) begin
      nxt_wr_cnt = 3'h0;
      nxt_rd_cnt = 3'h0;
    end
  end

  // Register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_cnt_ff <= 3'h0;
      rd_cnt_ff <= 3'h0;
      asm_ff    <= 32'h0000_0000;
    end else begin
      wr_cnt_ff <= nxt_wr_cnt;
      rd_cnt_ff <= nxt_rd_cnt;
      asm_ff    <= nxt_asm;
    end
  end

endmodule // path_conv

// *** tb/host_port_assertions.sv ***
// Checker for the host bus port, bound to host_bus_port.
// Assumes the host holds each cycle three clocks or more.
`timescale 1ns/1ps

module host_port_checker (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rstn,
  // Host pins
  input wire host_port_pkg::host_pins_t host_ctl,
  input wire logic [4:0]                host_addr,
  input wire logic [15:0]               host_din,
  input wire logic [15:0]               host_dout,
  input wire logic                      host_doe,
  // Straps and power
  input wire logic                      mode16_pin,
  input wire logic                      alt_signal_pin,
  input wire logic                      low_power,
  // Internal bus
  input wire logic                      int_wr_strobe,
  input wire host_port_pkg::int_req_t   int_wr_req,
  input wire logic [15:0]               int_rd_addr,
  input wire logic                      int_rd_fifo,
  input wire logic                      int_rd_strobe,
  input wire logic [31:0]               int_rd_data
);
  import host_port_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Raw cycle decode, before the pin synchronisers
  logic rd_act;  // Read cycle at the pins
  logic wr_act;  // Write cycle at the pins
  assign rd_act = host_ctl.cs && (alt_signal_pin ? host_ctl.transfer_strobe && host_ctl.rnw
                                                 : host_ctl.rd);
  assign wr_act = host_ctl.cs && (alt_signal_pin ? host_ctl.transfer_strobe && !host_ctl.rnw
                                                 : host_ctl.wr);

  // ==========================================================
  // Sequences
  sequence read_tail;
    $fell(host_doe);
  endsequence
  sequence lp_held;
    low_power[*4];
  endsequence
  sequence byte_read;
    (!mode16_pin)[*8] ##0 host_doe;
  endsequence

  // ==========================================================
  // Properties
  doe_start_a: assert property ($rose(host_doe) |-> $past(rd_act, 4) && !$past(rd_act, 5))
    else $error("data drive without a read cycle");
  doe_drop_a: assert property ($fell(host_doe) |-> $past(rd_act, 4) && !$past(rd_act, 3))
    else $error("data drive ends at wrong time");
  dout_steady_a: assert property (host_doe && $past(host_doe) |-> $stable(host_dout))
    else $error("read data moved during a read");
  rd_tail_a: assert property (int_rd_strobe |-> read_tail)
    else $error("internal read not at end of read");
  rd_pulse_a: assert property (int_rd_strobe |=> !int_rd_strobe)
    else $error("internal read strobe too long");
  wr_cause_a: assert property (int_wr_strobe |-> $past(wr_act, 4) && !$past(wr_act, 3))
    else $error("internal write not at write trailing edge");
  wr_pulse_a: assert property (int_wr_strobe |=> !int_wr_strobe until wr_act)
    else $error("internal write repeated without host write");
  req_hold_a: assert property (!int_wr_strobe |-> $stable(int_wr_req))
    else $error("write request moved without strobe");
  lp_quiet_a: assert property (lp_held |-> !int_wr_strobe && !int_rd_strobe)
    else $error("internal access in low power");
  doe_power_a: assert property (lp_held |-> !$rose(host_doe))
    else $error("read answered in low power");
  byte_upper_a: assert property (byte_read |-> host_dout[15:8] == 8'h00)
    else $error("upper byte driven in byte mode");
endmodule // host_port_checker

bind host_bus_port host_port_checker chk (.clk, .rstn, .host_ctl, .host_addr, .host_din,
  .host_dout, .host_doe, .mode16_pin, .alt_signal_pin, .low_power, .int_wr_strobe,
  .int_wr_req, .int_rd_addr, .int_rd_fifo, .int_rd_strobe, .int_rd_data);

// *** tb/host_model.sv ***
// Host processor model driving the host bus port pins.
// Assumes callers use cyc only; one whole cycle per call.
`timescale 1ns/1ps

module host_model (
  // Clock
  input  wire logic                        clk,
  // Host pins
  output host_port_pkg::host_pins_t        ctl,
  output logic [4:0]                       addr,
  output logic [15:0]                      din,
  input  wire logic [15:0]                 dout,
  // Signaling choice
  input  wire logic                        alt
);
  import host_port_pkg::*;

  // ==========================================================
  // Idle pins; data line not pulled, so it toggles when free
  initial begin
    ctl = '0;
    addr = 5'h00;
    din = 16'hA5C3;
  end

  // ==========================================================
  // whole cycle, held six clocks, no repeats issued
  task automatic cyc(input logic rd_i, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk);
    addr = a;
    din = rd_i ? ~din : d;
    ctl = '{cs: 1'b1, rd: !alt && rd_i, wr: !alt && !rd_i, transfer_strobe: alt, rnw: rd_i};
    repeat (6) @(negedge clk);
    q = dout;
    ctl = '0;
    // Data held past release for the pin synchronisers
    repeat (3) @(negedge clk);
    din = ~din;
    @(negedge clk);
  endtask
endmodule // host_model

// *** tb/test_indexed_host_port_access.sv ***
// Self-checking bench for the host bus port, random pieces and orders.
// Assumes host_model drives the pins and the checker is bound to the dut.
`timescale 1ns/1ps

module test_indexed_host_port_access;
  import host_port_pkg::*;
  // ==========================================================
  // Signals
  logic              clk, rstn, mode16_pin, alt_signal_pin, low_power;
  host_pins_t        host_ctl;
  logic [4:0]        host_addr;
  logic [15:0]       host_din, host_dout, q, int_rd_addr;
  logic              host_doe, int_wr_strobe, int_rd_fifo, int_rd_strobe;
  int_req_t          int_wr_req;
  int_req_t          got_q[$];   // Internal writes seen
  logic [31:0]       int_rd_data;
  logic [15:0]       idx[3];     // Index values written
  logic [3:0]        cfg;        // Byte order per path
  int                bad_count, cmp_count, rd_cnt, s;
  localparam logic [31:0] fifo_word = 32'hC3A5_5A3C;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  host_bus_port dut (.clk, .rstn, .host_ctl, .host_addr, .host_din, .host_dout, .host_doe,
    .mode16_pin, .alt_signal_pin, .low_power, .int_wr_strobe, .int_wr_req, .int_rd_addr,
    .int_rd_fifo, .int_rd_strobe, .int_rd_data);
  host_model host (.clk, .ctl(host_ctl), .addr(host_addr), .din(host_din),
    .dout(host_dout), .alt(alt_signal_pin));

  // ==========================================================
  // Internal side: register word derived from its address
  assign int_rd_data = int_rd_fifo ? fifo_word : {~int_rd_addr, int_rd_addr};
  always @(posedge clk) begin
    if (int_wr_strobe) got_q.push_back(int_wr_req);
    if (int_rd_strobe) rd_cnt++;
  end

  // ==========================================================
  // Expectations
  function automatic logic [31:0] mem(input int p);
    return (p == 3) ? fifo_word : {~idx[p], idx[p]};
  endfunction
  // Bit offset of piece i; big order mirrors the lanes
  function automatic int lane(input int i, input logic big);
    if (mode16_pin) return 16 * (i ^ int'(big));
    return 8 * (big ? 3 - i : i);
  endfunction
  function automatic logic [4:0] base(input int p);
    return (p == 3) ? 5'h18 : 5'(8 * p + 4);
  endfunction

  task automatic check(input logic [48:0] got, input logic [48:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One piece of path p: written, or read and compared
  task automatic piece(input int p, input int i, input logic [31:0] d, input logic rd_i);
    logic [4:0]  a;
    logic [15:0] e;
    a = base(p) + 5'(mode16_pin ? 2 * i : i);
    e = mode16_pin ? d[lane(i, cfg[p])+:16] : {8'h00, d[lane(i, cfg[p])+:8]};
    host.cyc(rd_i, a, e, q);
    if (rd_i) check(49'(q), 49'(e), "read piece");
  endtask

  // Pieces of all four paths interleaved; start piece random
  task automatic all_paths(input logic rd_i);
    int          n;
    int          r0;
    logic [31:0] d[4];
    n = mode16_pin ? 2 : 4;
    s = $urandom % n;
    r0 = rd_cnt;
    got_q.delete();
    for (int p = 0; p < 4; p++) d[p] = rd_i ? mem(p) : $urandom;
    for (int i = 0; i < n; i++)
      for (int p = 0; p < 4; p++) piece(p, (s + i) % n, d[p], rd_i);
    if (rd_i) check(49'(rd_cnt - r0), 49'd4, "read strobes");
    if (!rd_i) check(49'(got_q.size()), 49'd4, "write count");
    for (int p = 0; p < 4 && !rd_i; p++)
      check(got_q[p], {p == 3, p == 3 ? 16'h0 : idx[p], d[p]}, "int write");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    mode16_pin = 1'b1;
    alt_signal_pin = 1'b0;
    low_power = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    rd_cnt = 0;
    cfg = 4'h0;
    idx = '{16'h1234, 16'h1234, 16'h1234};
    void'($urandom(32'h1E9A));
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    // Locked after reset, so this write must vanish
    host.cyc(1'b0, 5'h00, 16'h5555, q);
    host.cyc(1'b1, 5'h00, 16'h0, q);
    check(49'(q), 49'h1234, "index after lock");
    host.cyc(1'b1, 5'h1C, 16'h0, q);
    check(49'(q), 49'h0, "config reset");
    $display("test reset_lock done");
    for (int k = 0; k < 2; k++) begin
      cfg = k ? ~cfg : 4'($urandom);
      // Reserved nibbles written high must read back zero
      host.cyc(1'b0, 5'h1E, {4'hF, cfg, 4'hF, 4'h0}, q);
      host.cyc(1'b1, 5'h1C, 16'h0, q);
      check(49'(q), 49'({4'h0, cfg, 4'h0, cfg}), "config shadows");
      for (int p = 0; p < 3; p++) begin
        idx[p] = 16'($urandom);
        host.cyc(1'b0, 5'(8 * p + (cfg[p] ? 2 : 0)), idx[p], q);
        host.cyc(1'b1, 5'(8 * p + (cfg[p] ? 2 : 0)), 16'h0, q);
        check(49'(q), 49'(idx[p]), "index word");
      end
      all_paths(1'b0);
      all_paths(1'b1);
      $display("test order_pass %0d done", k);
    end
    // Half-done dwords, then a power drop clears the counters
    host.cyc(1'b0, 5'h04, 16'h0F0F, q);
    host.cyc(1'b1, 5'h0C, 16'h0, q);
    low_power = 1'b1;
    repeat (10) @(negedge clk);
    host.cyc(1'b1, 5'h0C, 16'h0, q);
    low_power = 1'b0;
    repeat (4) @(negedge clk);
    got_q.delete();
    s = rd_cnt;
    host.cyc(1'b0, 5'h04, 16'h0F0F, q);
    host.cyc(1'b1, 5'h0C, 16'h0, q);
    check(49'(rd_cnt - s), 49'd0, "read count cleared");
    host.cyc(1'b0, 5'h04, 16'h0F0F, q);
    check(49'(got_q.size()), 49'd0, "write count cleared");
    host.cyc(1'b0, 5'h06, 16'h0F0F, q);
    check(49'(got_q.size()), 49'd1, "write after unlock");
    $display("test low_power done");
    // Byte mode with strobe and direction signaling
    mode16_pin = 1'b0;
    alt_signal_pin = 1'b1;
    repeat (4) @(negedge clk);
    all_paths(1'b0);
    all_paths(1'b1);
    $display("test byte_mode done");
    close_out();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule // test_indexed_host_port_access
